// File: rtl/sip_regs.svh
/*
  Constants for the serial programming port: opcodes, erased value,
  timing figures and counter width.
  Assumes the core clock period given here matches the real clock.
*/
`ifndef SIP_REGS_SVH
`define SIP_REGS_SVH

// ==========================================================
// Timing
// ==========================================================
`define SIP_CLK_PERIOD_NS 25
`define SIP_PAGE_WAIT_NS  4_500_000
`define SIP_BYTE_WAIT_NS  3_600_000
`define SIP_ERASE_WAIT_NS 9_000_000
`define SIP_CNT_W         20

// ==========================================================
// Instruction encodings and data values
// ==========================================================
`define SIP_PREFIX        8'hAC
`define SIP_UNLOCK_B2     8'h53
`define SIP_ERASE_B2      3'h4
`define SIP_RD_FLASH_HI   4'h2
`define SIP_LD_PAGE_HI    4'h4
`define SIP_WR_PAGE       8'h4C
`define SIP_RD_EE         8'hA0
`define SIP_WR_EE         8'hC0
`define SIP_ERASED        8'hFF
`define SIP_HBIT          3
`define SIP_WORD_BITS     6

`endif

// File: rtl/sip_pkg.sv
/*
  Types shared by the serial programming port.
  Assumes nothing of its surroundings.
*/
package sip_pkg;
  // Self-timed operation in progress
  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_PAGE  = 2'h1,
    OP_EE    = 2'h2,
    OP_ERASE = 2'h3
  } sip_op_type;

  // Decoded instruction
  typedef enum logic [2:0] {
    CMD_NONE     = 3'h0,
    CMD_UNLOCK   = 3'h1,
    CMD_ERASE    = 3'h2,
    CMD_RD_FLASH = 3'h3,
    CMD_LD_PAGE  = 3'h4,
    CMD_WR_PAGE  = 3'h5,
    CMD_RD_EE    = 3'h6,
    CMD_WR_EE    = 3'h7
  } sip_cmd_type;
endpackage : sip_pkg

// File: rtl/sip_mem.sv
/*
  Simple dual-port byte memory with registered read data.
  Assumes one clock for both ports; contents have no reset.
*/
`timescale 1ns/10ps
module sip_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk_in,     // core clock
  input  wire logic          arst_n_in,  // async reset, low
  input  wire logic          we_in,      // write strobe
  input  wire logic [AW-1:0] waddr_in,   // write address
  input  wire logic [DW-1:0] wdata_in,   // write data
  input  wire logic [AW-1:0] raddr_in,   // read address
  output logic      [DW-1:0] rdata_out   // registered read data
);
  logic [DW-1:0] mem [2**AW];

  // Array write; no reset so it maps onto RAM
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Read data register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule : sip_mem

// File: rtl/sip_top.sv
/*
  Serial in-system programming port: four-byte instructions over
  SCK/MOSI/MISO, unlock check, page buffer, flash and EEPROM arrays,
  chip erase and self-timed busy windows.
  Assumes SCK, MOSI and the reset pin are asynchronous to MCLK_IN and
  that SCK high and low phases last at least three core clocks.
*/
// Function
// - Programming accepted only while reset pin is low; MISO is output
// - No program or erase until unlock instruction has completed
// - EEPROM byte write overwrites old value, erasing it automatically
// - Chip erase sets every flash and EEPROM byte to FF
// - MOSI is sampled on each rising SCK edge
// - MISO changes on each falling SCK edge
// - In sync, second unlock byte 53 echoes during third byte
// - Page load carries one data byte and six-bit word address
// - Page commit carries eight page bits; buffered page written there
// - EEPROM written one byte per instruction, with fixed wait
// - Read instruction returns addressed content on MISO
// - Reset pin high ends programming and starts normal operation
// - Reads inside a page being written give FF until done
// - Unlock is AC then 53, then two free bytes
// - Reads of EEPROM byte being written give FF until done
// - Chip erase is AC then 100x xxxx, erasing both arrays
`timescale 1ns/10ps
`include "sip_regs.svh"
module sip_top #(
  parameter int FLASH_WAW = 14,
  parameter int EE_AW     = 9,
  parameter int PAGE_CYC  = `SIP_PAGE_WAIT_NS / `SIP_CLK_PERIOD_NS,
  parameter int BYTE_CYC  = `SIP_BYTE_WAIT_NS / `SIP_CLK_PERIOD_NS,
  parameter int ERASE_CYC = `SIP_ERASE_WAIT_NS / `SIP_CLK_PERIOD_NS
) (
  input  wire logic MCLK_IN,        // core clock, 40 MHz
  input  wire logic ARST_N_IN,      // async reset, low
  input  wire logic RESET_PIN_N_IN, // device reset pin, low = program
  input  wire logic SCK_IN,         // serial clock from programmer
  input  wire logic MOSI_IN,        // serial data in
  output logic      MISO_OUT,       // serial data out
  output logic      PROG_MODE_OUT,  // programming mode active
  output logic      RUN_OUT,        // normal operation
  output logic      BUSY_OUT        // self-timed write in progress
);
  // ==========================================================
  // Sizes and limits
  // ==========================================================
  localparam int CW    = `SIP_CNT_W;
  localparam int FB_AW = FLASH_WAW + 1;
  localparam int PG_W  = FLASH_WAW - `SIP_WORD_BITS;
  localparam int PB_AW = `SIP_WORD_BITS + 1;
  localparam int PB_N  = 2**PB_AW;
  // Busy window never shorter than the array walk it covers
  localparam int PG_L  = (PAGE_CYC > PB_N + 1) ? PAGE_CYC : PB_N + 2;
  // Erase walks the larger array, so small flash still clears EEPROM
  localparam int WALK  = (2**FB_AW > 2**EE_AW) ? 2**FB_AW : 2**EE_AW;
  localparam int ER_L  = (ERASE_CYC > WALK) ? ERASE_CYC : WALK + 1;
  localparam logic [CW-1:0] PAGE_LIM  = CW'(PG_L - 1);
  localparam logic [CW-1:0] BYTE_LIM  = CW'(BYTE_CYC - 1);
  localparam logic [CW-1:0] ERASE_LIM = CW'(ER_L - 1);
  localparam logic [CW-1:0] FL_BYTES  = CW'(2**FB_AW);
  localparam logic [CW-1:0] EE_BYTES  = CW'(2**EE_AW);
  localparam logic [CW-1:0] PB_LAST   = CW'(PB_N);

  // Instruction decode, shared by read fetch and execute
  function automatic sip_pkg::sip_cmd_type sip_decode(
    input logic [7:0] c1,
    input logic [7:0] c2
  );
    sip_pkg::sip_cmd_type r;
    r = sip_pkg::CMD_NONE;
    if (c1 == `SIP_PREFIX && c2 == `SIP_UNLOCK_B2) begin
      r = sip_pkg::CMD_UNLOCK;
    end else if (c1 == `SIP_PREFIX && c2[7:5] == `SIP_ERASE_B2) begin
      r = sip_pkg::CMD_ERASE;
    end else if (c1[7:4] == `SIP_RD_FLASH_HI && c1[2:0] == 3'h0) begin
      r = sip_pkg::CMD_RD_FLASH;
    end else if (c1[7:4] == `SIP_LD_PAGE_HI && c1[2:0] == 3'h0) begin
      r = sip_pkg::CMD_LD_PAGE;
    end else if (c1 == `SIP_WR_PAGE) begin
      r = sip_pkg::CMD_WR_PAGE;
    end else if (c1 == `SIP_RD_EE) begin
      r = sip_pkg::CMD_RD_EE;
    end else if (c1 == `SIP_WR_EE) begin
      r = sip_pkg::CMD_WR_EE;
    end
    return r;
  endfunction : sip_decode

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [2:0] sck_s_q;
  logic [1:0] mosi_s_q;
  logic [1:0] rst_s_q;
  logic       rise;
  logic       fall;
  logic       pin_low;

  // Two flops per pin; third SCK stage only feeds edge finding
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      sck_s_q  <= 3'h0;
      mosi_s_q <= 2'h0;
      rst_s_q  <= 2'h3;
    end else begin
      sck_s_q  <= {sck_s_q[1:0], SCK_IN};
      mosi_s_q <= {mosi_s_q[0], MOSI_IN};
      rst_s_q  <= {rst_s_q[0], RESET_PIN_N_IN};
    end
  end

  // Edges are seen only if each SCK phase spans three clocks
  assign rise    = sck_s_q[1] & ~sck_s_q[2];
  assign fall    = ~sck_s_q[1] & sck_s_q[2];
  assign pin_low = ~rst_s_q[1];

  // ==========================================================
  // Serial shifter and instruction bytes
  // ==========================================================
  logic [4:0]           bit_cnt_q, bit_cnt_d;
  logic [7:0]           rx_q, rx_d, rx_next;
  logic [7:0]           b1_q, b1_d, b2_q, b2_d, b3_q, b3_d;
  logic [7:0]           out_sr_q, out_sr_d;
  logic                 miso_q, miso_d;
  logic                 unl_q, unl_d;
  logic                 ld1_q, ld1_d, ld2_q, ld2_d;
  logic                 exec;
  logic [15:0]          addr16;
  logic [7:0]           rd_byte;
  logic                 fl_hit, ee_hit;
  sip_pkg::sip_cmd_type cmd;
  sip_pkg::sip_op_type  op_q, op_d;
  logic [CW-1:0]        cnt_q, cnt_d;
  logic [PG_W-1:0]      page_q, page_d;
  logic [EE_AW-1:0]     ee_a_q, ee_a_d;
  logic [7:0]           ee_dat_q, ee_dat_d;
  logic [7:0]           fl_rdata, ee_rdata, pb_rdata;

  assign rx_next = {rx_q[6:0], mosi_s_q[1]};
  assign cmd     = sip_decode(b1_q, b2_q);
  assign addr16  = {b2_q, b3_q};

  // Busy windows hide the old content behind the erased value
  assign fl_hit = (op_q == sip_pkg::OP_ERASE) ||
                  (op_q == sip_pkg::OP_PAGE &&
                   addr16[FLASH_WAW-1:`SIP_WORD_BITS] == page_q);
  assign ee_hit = (op_q == sip_pkg::OP_ERASE) ||
                  (op_q == sip_pkg::OP_EE &&
                   addr16[EE_AW-1:0] == ee_a_q);
  always_comb begin
    if (cmd == sip_pkg::CMD_RD_FLASH) begin
      rd_byte = fl_hit ? `SIP_ERASED : fl_rdata;
    end else begin
      rd_byte = ee_hit ? `SIP_ERASED : ee_rdata;
    end
  end

  // Next state of the shifter; reset pin high clears the link
  always_comb begin
    bit_cnt_d = bit_cnt_q;
    rx_d      = rx_q;
    b1_d      = b1_q;
    b2_d      = b2_q;
    b3_d      = b3_q;
    out_sr_d  = out_sr_q;
    miso_d    = miso_q;
    unl_d     = unl_q;
    ld1_d     = 1'b0;
    ld2_d     = ld1_q;
    exec      = 1'b0;
    if (!pin_low) begin
      bit_cnt_d = 5'h0;
      out_sr_d  = 8'h00;
      miso_d    = 1'b0;
      unl_d     = 1'b0;
      ld2_d     = 1'b0;
    end else begin
      if (rise) begin
        rx_d      = rx_next;
        bit_cnt_d = bit_cnt_q + 5'h1;
        if (bit_cnt_q[2:0] == 3'h7) begin
          out_sr_d = rx_next;
          case (bit_cnt_q[4:3])
            2'h0: begin
              b1_d = rx_next;
            end
            2'h1: begin
              b2_d = rx_next;
            end
            2'h2: begin
              b3_d  = rx_next;
              ld1_d = 1'b1;
            end
            default: begin
              exec = 1'b1;
            end
          endcase
        end
      end else if (fall) begin
        miso_d   = out_sr_q[7];
        out_sr_d = {out_sr_q[6:0], 1'b0};
      end
      // Read data replaces the echo before the fourth byte shifts out
      if (ld2_q && unl_q && (cmd == sip_pkg::CMD_RD_FLASH ||
                             cmd == sip_pkg::CMD_RD_EE)) begin
        out_sr_d = rd_byte;
      end
      if (exec && cmd == sip_pkg::CMD_UNLOCK) begin
        unl_d = 1'b1;
      end
    end
  end

  // Shifter registers
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      bit_cnt_q <= 5'h0;
      rx_q      <= 8'h00;
      b1_q      <= 8'h00;
      b2_q      <= 8'h00;
      b3_q      <= 8'h00;
      out_sr_q  <= 8'h00;
      miso_q    <= 1'b0;
      unl_q     <= 1'b0;
      ld1_q     <= 1'b0;
      ld2_q     <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      rx_q      <= rx_d;
      b1_q      <= b1_d;
      b2_q      <= b2_d;
      b3_q      <= b3_d;
      out_sr_q  <= out_sr_d;
      miso_q    <= miso_d;
      unl_q     <= unl_d;
      ld1_q     <= ld1_d;
      ld2_q     <= ld2_d;
    end
  end

  // ==========================================================
  // Self-timed write and erase sequencer
  // ==========================================================
  logic             busy_end;
  logic [CW-1:0]    cm1;
  logic             fl_we, ee_we, pb_we;
  logic [FB_AW-1:0] fl_waddr;
  logic [7:0]       fl_wdata, ee_wdata;
  logic [EE_AW-1:0] ee_waddr;

  always_comb begin
    case (op_q)
      sip_pkg::OP_PAGE: busy_end = (cnt_q >= PAGE_LIM);
      sip_pkg::OP_EE:   busy_end = (cnt_q >= BYTE_LIM);
      sip_pkg::OP_ERASE: busy_end = (cnt_q >= ERASE_LIM);
      default:          busy_end = 1'b0;
    endcase
  end

  // New operations start only when idle and unlocked
  always_comb begin
    op_d     = op_q;
    cnt_d    = cnt_q + CW'(1);
    page_d   = page_q;
    ee_a_d   = ee_a_q;
    ee_dat_d = ee_dat_q;
    case (op_q)
      sip_pkg::OP_IDLE: begin
        cnt_d = {CW{1'b0}};
        if (exec && unl_q) begin
          case (cmd)
            sip_pkg::CMD_ERASE: begin
              op_d = sip_pkg::OP_ERASE;
            end
            sip_pkg::CMD_WR_PAGE: begin
              op_d   = sip_pkg::OP_PAGE;
              page_d = addr16[FLASH_WAW-1:`SIP_WORD_BITS];
            end
            sip_pkg::CMD_WR_EE: begin
              op_d     = sip_pkg::OP_EE;
              ee_a_d   = addr16[EE_AW-1:0];
              ee_dat_d = rx_next;
            end
            default: begin
              op_d = sip_pkg::OP_IDLE;
            end
          endcase
        end
      end
      default: begin
        if (busy_end) begin
          op_d = sip_pkg::OP_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      op_q     <= sip_pkg::OP_IDLE;
      cnt_q    <= {CW{1'b0}};
      page_q   <= {PG_W{1'b0}};
      ee_a_q   <= {EE_AW{1'b0}};
      ee_dat_q <= 8'h00;
    end else begin
      op_q     <= op_d;
      cnt_q    <= cnt_d;
      page_q   <= page_d;
      ee_a_q   <= ee_a_d;
      ee_dat_q <= ee_dat_d;
    end
  end

  // Array write ports: page copy lags buffer read by one clock
  assign cm1      = cnt_q - CW'(1);
  assign fl_we    = (op_q == sip_pkg::OP_PAGE && cnt_q != {CW{1'b0}} &&
                     cnt_q <= PB_LAST) ||
                    (op_q == sip_pkg::OP_ERASE && cnt_q < FL_BYTES);
  assign fl_waddr = (op_q == sip_pkg::OP_ERASE) ? cnt_q[FB_AW-1:0]
                    : {page_q, cm1[PB_AW-1:0]};
  assign fl_wdata = (op_q == sip_pkg::OP_ERASE) ? `SIP_ERASED
                    : pb_rdata;
  // Whole-byte overwrite means no separate erase is needed
  assign ee_we    = (op_q == sip_pkg::OP_EE && cnt_q == {CW{1'b0}}) ||
                    (op_q == sip_pkg::OP_ERASE && cnt_q < EE_BYTES);
  assign ee_waddr = (op_q == sip_pkg::OP_ERASE) ? cnt_q[EE_AW-1:0]
                    : ee_a_q;
  assign ee_wdata = (op_q == sip_pkg::OP_ERASE) ? `SIP_ERASED
                    : ee_dat_q;
  // Byte address is word index then high/low select bit
  assign pb_we    = exec && unl_q && cmd == sip_pkg::CMD_LD_PAGE;

  // ==========================================================
  // Arrays
  // ==========================================================
  sip_mem #(.AW(PB_AW), .DW(8)) u_pbuf (
    .clk_in    (MCLK_IN),
    .arst_n_in (ARST_N_IN),
    .we_in     (pb_we),
    .waddr_in  ({b3_q[`SIP_WORD_BITS-1:0], b1_q[`SIP_HBIT]}),
    .wdata_in  (rx_next),
    .raddr_in  (cnt_q[PB_AW-1:0]),
    .rdata_out (pb_rdata)
  );
  sip_mem #(.AW(FB_AW), .DW(8)) u_flash (
    .clk_in    (MCLK_IN),
    .arst_n_in (ARST_N_IN),
    .we_in     (fl_we),
    .waddr_in  (fl_waddr),
    .wdata_in  (fl_wdata),
    .raddr_in  ({addr16[FLASH_WAW-1:0], b1_q[`SIP_HBIT]}),
    .rdata_out (fl_rdata)
  );
  sip_mem #(.AW(EE_AW), .DW(8)) u_eeprom (
    .clk_in    (MCLK_IN),
    .arst_n_in (ARST_N_IN),
    .we_in     (ee_we),
    .waddr_in  (ee_waddr),
    .wdata_in  (ee_wdata),
    .raddr_in  (addr16[EE_AW-1:0]),
    .rdata_out (ee_rdata)
  );

  // Outputs
  assign MISO_OUT      = miso_q;
  assign PROG_MODE_OUT = pin_low;
  assign RUN_OUT       = ~pin_low;
  assign BUSY_OUT      = (op_q != sip_pkg::OP_IDLE);

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  prog_gate_a: assert property (
    !pin_low |=> !unl_q && bit_cnt_q == 5'h0)
    else $error("link not cleared while reset pin high");
  unlock_first_a: assert property (
    op_q == sip_pkg::OP_IDLE && op_d != sip_pkg::OP_IDLE |-> unl_q)
    else $error("operation started before unlock");
  erase_ff_a: assert property (
    op_q == sip_pkg::OP_ERASE && (fl_we || ee_we)
    |-> fl_wdata == `SIP_ERASED && ee_wdata == `SIP_ERASED)
    else $error("erase wrote a value other than FF");
  ee_write_a: assert property (
    op_q == sip_pkg::OP_IDLE && op_d == sip_pkg::OP_EE
    |=> ee_we && ee_waddr == $past(addr16[EE_AW-1:0]))
    else $error("EEPROM byte not written at its address");
  sample_rise_a: assert property (
    rise && pin_low |=> bit_cnt_q == $past(bit_cnt_q) + 5'h1)
    else $error("rising SCK edge not counted");
  miso_fall_a: assert property (
    pin_low && !fall |=> $stable(MISO_OUT))
    else $error("MISO changed away from a falling edge");
  echo_a: assert property (
    pin_low && rise && bit_cnt_q == 5'hF |=> out_sr_q == b2_q)
    else $error("second byte not queued for echo");
  page_addr_a: assert property (
    op_q == sip_pkg::OP_PAGE && fl_we
    |-> fl_waddr[FB_AW-1:PB_AW] == page_q)
    else $error("page written outside committed page");
  busy_ff_a: assert property (
    pin_low && ld2_q && unl_q && cmd == sip_pkg::CMD_RD_FLASH && fl_hit
    |=> out_sr_q == `SIP_ERASED)
    else $error("busy flash page read not FF");
  relock_a: assert property (!pin_low ##1 pin_low |-> !unl_q)
    else $error("unlock survived a reset pulse");

  unlock_c: cover property (exec && cmd == sip_pkg::CMD_UNLOCK);
  page_c: cover property (op_q == sip_pkg::OP_PAGE && busy_end);
  erase_c: cover property (op_q == sip_pkg::OP_ERASE && busy_end);
  eeread_c: cover property (ld2_q && cmd == sip_pkg::CMD_RD_EE && ee_hit);
endmodule : sip_top

// File: tb/sip_prog.sv
/*
  Programmer model: drives SCK, MOSI and the reset pin, samples MISO.
  Assumes the core clock on clk_in; every change follows its fall.
*/
`timescale 1ns/10ps
module sip_prog #(
  parameter int HALF = 4  // SCK low for HALF - 1 core clocks, high for HALF + 1
) (
  input  wire logic clk_in,        // core clock
  input  wire logic miso_in,       // serial data from device
  output logic      sck_out,       // serial clock, idle low
  output logic      mosi_out,      // serial data to device
  output logic      rst_pin_n_out  // device reset pin
);
  // ==========================================================
  // Power-up
  // ==========================================================
  // Pin and SCK low from the start, so no extra pulse is needed
  initial begin
    sck_out       = 1'b0;
    mosi_out      = 1'b0;
    rst_pin_n_out = 1'b0;
  end

  // ==========================================================
  // Link tasks
  // ==========================================================
  // Reset pin level; pulses end a session or regain sync
  task automatic set_pin(input logic v);
    @(negedge clk_in);
    rst_pin_n_out = v;
  endtask : set_pin

  // Four bytes MSB first, reply bit taken as SCK rises
  task automatic xfer(input logic [31:0] ins, output logic [31:0] rsp);
    for (int i = 31; i >= 0; i--) begin
      @(negedge clk_in);
      sck_out  = 1'b0;
      mosi_out = ins[i];
      repeat (HALF - 1) @(negedge clk_in);
      rsp[i]  = miso_in;
      sck_out = 1'b1;
      repeat (HALF) @(negedge clk_in);
    end
    sck_out = 1'b0;
  endtask : xfer
endmodule : sip_prog

// File: tb/tb_top.sv
/*
  Self-checking bench for the serial programming port.
  Assumes the programmer model in sip_prog and shortened busy windows.
*/
`timescale 1ns/10ps
`include "sip_regs.svh"
module tb_top;
  // Busy windows longer than one read, so reads land inside them
  localparam int PAGE_CYC  = 400;
  localparam int BYTE_CYC  = 400;
  localparam int ERASE_CYC = 600;
  logic        mclk, arst_n, sck, mosi, pin_n;
  logic        miso, prog_mode, run, busy;
  logic [31:0] rsp;
  logic [7:0]  d;
  int          err_count;
  int          check_count;

  sip_top #(.FLASH_WAW(7), .EE_AW(9), .PAGE_CYC(PAGE_CYC),
    .BYTE_CYC(BYTE_CYC), .ERASE_CYC(ERASE_CYC)) dut (
    .MCLK_IN(mclk), .ARST_N_IN(arst_n), .RESET_PIN_N_IN(pin_n),
    .SCK_IN(sck), .MOSI_IN(mosi), .MISO_OUT(miso),
    .PROG_MODE_OUT(prog_mode), .RUN_OUT(run), .BUSY_OUT(busy));
  sip_prog prog (.clk_in(mclk), .miso_in(miso), .sck_out(sck),
    .mosi_out(mosi), .rst_pin_n_out(pin_n));

  // Core clock kept running all along
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string msg);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  // Busy must be up on entry and drop inside (lo, hi] cycles
  task automatic wait_ready(input int lo, input int hi);
    int n;
    n = 0;
    while (busy !== 1'b0 && n <= hi) begin
      @(negedge mclk);
      n++;
    end
    check({7'h00, (n > lo && n <= hi)}, 8'h01, "busy span");
  endtask : wait_ready

  task automatic rd_fl(input logic [6:0] w, input logic h);
    prog.xfer({4'h2, h, 3'h0, 8'h00, 1'b0, w, 8'h00}, rsp);
    d = rsp[7:0];
  endtask : rd_fl

  task automatic ld(input logic [5:0] w, input logic h, input logic [7:0] v);
    prog.xfer({`SIP_LD_PAGE_HI, h, 3'h0, 8'h00, 2'h0, w, v}, rsp);
  endtask : ld

  task automatic rd_ee(input logic [8:0] a);
    prog.xfer({`SIP_RD_EE, 7'h00, a, 8'h00}, rsp);
    d = rsp[7:0];
  endtask : rd_ee

  task automatic wr_ee(input logic [8:0] a, input logic [7:0] v);
    prog.xfer({`SIP_WR_EE, 7'h00, a, v}, rsp);
  endtask : wr_ee

  task automatic unlock();
    prog.xfer({`SIP_PREFIX, `SIP_UNLOCK_B2, 16'h0000}, rsp);
    check(rsp[15:8], `SIP_UNLOCK_B2, "echo");
    check(rsp[23:16], `SIP_PREFIX, "byte one echo");
  endtask : unlock

  task automatic erase();
    prog.xfer({`SIP_PREFIX, `SIP_ERASE_B2, 5'h00, 16'h0000}, rsp);
  endtask : erase

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_lock();
    check({7'h00, prog_mode}, 8'h01, "prog mode");
    check({7'h00, run}, 8'h00, "run");
    wr_ee(9'h005, 8'h11);
    check({7'h00, busy}, 8'h00, "write before unlock");
  endtask : t_lock

  task automatic t_erase();
    erase();
    wait_ready(ERASE_CYC - 12, ERASE_CYC);
    rd_fl(7'h00, 1'b0);
    check(d, `SIP_ERASED, "flash erased");
    rd_fl(7'h7f, 1'b1);
    check(d, `SIP_ERASED, "flash erased");
    rd_ee(9'h1ff);
    check(d, `SIP_ERASED, "eeprom erased");
  endtask : t_erase

  // Read inside the busy window, then overwrite with no erase
  task automatic t_ee();
    wr_ee(9'h105, 8'h3c);
    rd_ee(9'h105);
    check(d, `SIP_ERASED, "eeprom busy read");
    wait_ready(BYTE_CYC - 280, BYTE_CYC - 240);
    rd_ee(9'h105);
    check(d, 8'h3c, "eeprom data");
    wr_ee(9'h105, 8'ha5);
    wait_ready(BYTE_CYC - 12, BYTE_CYC);
    rd_ee(9'h105);
    check(d, 8'ha5, "eeprom rewrite");
  endtask : t_ee

  // Two pages; the buffer keeps halves that were not reloaded
  task automatic t_page();
    ld(6'h00, 1'b0, 8'h12);
    ld(6'h00, 1'b1, 8'h34);
    ld(6'h01, 1'b0, 8'h56);
    ld(6'h01, 1'b1, 8'h78);
    prog.xfer({`SIP_WR_PAGE, 24'h00_0000}, rsp);
    rd_fl(7'h01, 1'b1);
    check(d, `SIP_ERASED, "page busy read");
    wait_ready(PAGE_CYC - 280, PAGE_CYC - 240);
    rd_fl(7'h00, 1'b1);
    check(d, 8'h34, "flash high");
    rd_fl(7'h01, 1'b0);
    check(d, 8'h56, "flash low");
    ld(6'h00, 1'b0, 8'h9a);
    prog.xfer({`SIP_WR_PAGE, 8'h00, 8'h40, 8'h00}, rsp);
    wait_ready(PAGE_CYC - 12, PAGE_CYC);
    rd_fl(7'h40, 1'b0);
    check(d, 8'h9a, "page one low");
    rd_fl(7'h40, 1'b1);
    check(d, 8'h34, "page one high");
    rd_fl(7'h00, 1'b0);
    check(d, 8'h12, "page zero kept");
  endtask : t_page

  // Session end, re-entry, and erase refused until unlocked again
  task automatic t_exit();
    prog.set_pin(1'b1);
    repeat (4) @(negedge mclk);
    check({7'h00, prog_mode}, 8'h00, "left prog");
    check({7'h00, run}, 8'h01, "running");
    check({7'h00, miso}, 8'h00, "miso idle");
    prog.set_pin(1'b0);
    repeat (4) @(negedge mclk);
    erase();
    check({7'h00, busy}, 8'h00, "erase locked");
    unlock();
    rd_fl(7'h00, 1'b0);
    check(d, 8'h12, "not erased");
  endtask : t_exit

  // ==========================================================
  // Verdict, watchdog and main sequence
  // ==========================================================
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // About 27 instructions of 256 cycles plus busy windows
  initial begin
    repeat (30000) @(negedge mclk);
    err_count++;
    stop_test();
  end

  initial begin
    err_count   = 0;
    check_count = 0;
    arst_n      = 1'b0;
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    repeat (20) @(negedge mclk);
    t_lock();
    unlock();
    t_erase();
    t_ee();
    t_page();
    t_exit();
    stop_test();
  end
endmodule : tb_top
